// [logic/tape_if_pkg.sv]
// Purpose: shared constants for the tape transport interface control
// Assumes: 200 MHz system clock
// Notes: connector pins are active low, inside logic is active high
package tape_if_pkg;
    localparam int CLK_MHZ = 200;
    localparam int WRITE_SAMPLE_NS = 2000;
    localparam int REWIND_PULSE_NS = 5000;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] WRITE_SAMPLE_CYCLES =
        CNT_W'((WRITE_SAMPLE_NS * CLK_MHZ) / 1000);
    localparam logic [CNT_W-1:0] REWIND_PULSE_CYCLES =
        CNT_W'((REWIND_PULSE_NS * CLK_MHZ) / 1000);
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // index of each synchronised pin in the input vector
    localparam int IN_SFC = 0;
    localparam int IN_SRC = 1;
    localparam int IN_OVW = 2;
    localparam int IN_RWC = 3;
    localparam int IN_SEL = 4;
    localparam int IN_SWS = 5;
    localparam int IN_OFF = 6;
    localparam int IN_TNG = 7;
    localparam int IN_LP = 8;
    localparam int IN_EOT = 9;
    localparam int IN_BSY = 10;
    localparam int IN_BKN = 11;
    localparam int IN_WAR = 12;
    localparam int IN_PNL = 13;
    localparam int IN_ONL = 14;
    localparam int IN_WP = 15;
    localparam int NUM_IN = 16;

    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam int CTRL_OFFLINE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;
endpackage

// [logic/tape_if_ctrl.sv]
// Purpose: interface control of a tape transport with an Avalon-MM port
// Assumes: all pins asynchronous to clk_sys
// Notes: outputs are registered, so each lags its cause by one clock
`timescale 1ns/1ps
module tape_if_ctrl
    import tape_if_pkg::*;
#(
    parameter logic [CNT_W-1:0] WRITE_SAMPLE = WRITE_SAMPLE_CYCLES,
    parameter logic [CNT_W-1:0] REWIND_PULSE = REWIND_PULSE_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic sync_forward_cmd_n,
    input wire logic sync_reverse_cmd_n,
    input wire logic overwrite_cmd_n,
    input wire logic rewind_cmd_n,
    input wire logic unit_select_n,
    input wire logic set_write_status_n,
    input wire logic go_offline_cmd_n,
    input wire logic tape_moving_n,
    input wire logic at_load_point_n,
    input wire logic tape_end_marker_n,
    input wire logic busy_in_n,
    input wire logic broken_tape_n,
    input wire logic write_amp_reset_n,
    input wire logic panel_rewind_n,
    input wire logic unit_online_n,
    input wire logic write_protect_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic run_normal_n,
    output logic dir_forward_n,
    output logic dir_reverse_n,
    output logic write_select_n,
    output logic erase_head_disable_n,
    output logic rewind_pulse_out_n,
    output logic offline_req_n,
    output logic online_status_n,
    output logic rewinding_status_n,
    output logic write_protected_status_n,
    output logic load_point_status_n,
    output logic ready_status_n,
    output logic end_of_tape_status_n,
    output logic tape_running_status_n
);
    function automatic logic [CNT_W-1:0] count_down(
        input logic [CNT_W-1:0] c);
        count_down = (c == CNT_ZERO) ? CNT_ZERO : c - CNT_ONE;
    endfunction

    logic [NUM_IN-1:0] pin_raw;
    logic [NUM_IN-1:0] meta_q;
    logic [NUM_IN-1:0] in_q;
    logic sync_forward_cmd, src, overwrite_cmd, rewind_cmd, set_write_status, off_cmd, moving, lp, marker;
    logic busy, broken, war, panel, sel_onl, motion, rewinding;
    logic [31:0] ctrl_q;
    logic dir_q, dir_prev_q, interlock_q;
    logic motion_prev_q, write_q, ovw_cap_q, ovw_mode_q;
    logic [CNT_W-1:0] sample_cnt_q;
    logic [CNT_W-1:0] rew_cnt_q;
    logic rew_q, rew_prev_q, eot_q, marker_prev_q;
    bus_state_t bus_q;
    logic dir_chg, motion_start, sample_end;

    // inversion at the connector
    assign pin_raw = ~{write_protect_n, unit_online_n, panel_rewind_n,
        write_amp_reset_n, broken_tape_n, busy_in_n, tape_end_marker_n,
        at_load_point_n, tape_moving_n, go_offline_cmd_n,
        set_write_status_n, unit_select_n, rewind_cmd_n, overwrite_cmd_n,
        sync_reverse_cmd_n, sync_forward_cmd_n};

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= '0;
            in_q <= '0;
        end
        else
        begin
            meta_q <= pin_raw;
            in_q <= meta_q;
        end
    end

    assign sync_forward_cmd = in_q[IN_SFC];
    assign src = in_q[IN_SRC];
    assign overwrite_cmd = in_q[IN_OVW];
    assign rewind_cmd = in_q[IN_RWC];
    assign set_write_status = in_q[IN_SWS];
    assign off_cmd = in_q[IN_OFF];
    assign moving = in_q[IN_TNG];
    assign lp = in_q[IN_LP];
    assign marker = in_q[IN_EOT];
    assign busy = in_q[IN_BSY];
    assign broken = in_q[IN_BKN];
    assign war = in_q[IN_WAR];
    assign panel = in_q[IN_PNL];
    // software can hold the unit off line from the register port
    assign sel_onl = in_q[IN_SEL] & in_q[IN_ONL]
        & ~ctrl_q[CTRL_OFFLINE_BIT];
    assign motion = sync_forward_cmd | src;
    assign rewinding = rew_q | panel;
    assign dir_chg = dir_q ^ dir_prev_q;
    assign motion_start = motion & ~motion_prev_q & sel_onl;
    assign sample_end = (sample_cnt_q == CNT_ONE);

    // direction and stop-before-reverse interlock
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dir_q <= 1'b1;
            dir_prev_q <= 1'b1;
            interlock_q <= 1'b0;
        end
        else
        begin
            if (sync_forward_cmd && !src)
                dir_q <= 1'b1;
            else if (src && !sync_forward_cmd)
                dir_q <= 1'b0;
            dir_prev_q <= dir_q;
            if (!moving)
                interlock_q <= 1'b0;
            else if (dir_chg)
                interlock_q <= 1'b1;
        end
    end

    // write sampling one-shot and write select flops
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            motion_prev_q <= 1'b0;
            sample_cnt_q <= CNT_ZERO;
            write_q <= 1'b0;
            ovw_cap_q <= 1'b0;
            ovw_mode_q <= 1'b0;
        end
        else
        begin
            motion_prev_q <= motion;
            if (motion_start)
                sample_cnt_q <= WRITE_SAMPLE;
            else
                sample_cnt_q <= count_down(sample_cnt_q);
            // write status is not dropped at motion end, avoiding glitches
            if (sample_end)
            begin
                write_q <= set_write_status;
                ovw_cap_q <= overwrite_cmd;
            end
            if (motion_start && overwrite_cmd)
                ovw_mode_q <= 1'b1;
            else if (war)
                ovw_mode_q <= 1'b0;
        end
    end

    // rewind flop, its pulse, and end of tape latch
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rew_q <= 1'b0;
            rew_prev_q <= 1'b0;
            rew_cnt_q <= CNT_ZERO;
            eot_q <= 1'b0;
            marker_prev_q <= 1'b0;
        end
        else
        begin
            if (broken || (lp && !moving))
                rew_q <= 1'b0;
            else if (rewind_cmd && sel_onl && !lp)
                rew_q <= 1'b1;
            rew_prev_q <= rew_q;
            if (rew_q && !rew_prev_q)
                rew_cnt_q <= REWIND_PULSE;
            else
                rew_cnt_q <= count_down(rew_cnt_q);
            marker_prev_q <= marker;
            if (broken)
                eot_q <= 1'b0;
            else if (marker && !rewinding && dir_q)
                eot_q <= 1'b1;
            else if (!marker && marker_prev_q && !dir_q)
                eot_q <= 1'b0;
        end
    end

    // motion and write outputs, all registered and active low
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_normal_n <= 1'b1;
            dir_forward_n <= 1'b1;
            dir_reverse_n <= 1'b1;
            write_select_n <= 1'b1;
            erase_head_disable_n <= 1'b1;
            rewind_pulse_out_n <= 1'b1;
            offline_req_n <= 1'b1;
        end
        else
        begin
            run_normal_n <= ~(motion && sel_onl && !busy && !(src && lp)
                && !interlock_q);
            dir_forward_n <= ~(dir_q && sel_onl && !busy);
            dir_reverse_n <= ~(!dir_q && sel_onl && !busy && !lp);
            write_select_n <= ~((write_q && !ovw_cap_q)
                || (ovw_mode_q && ovw_cap_q && set_write_status && motion));
            erase_head_disable_n <= ~(ovw_mode_q && ovw_cap_q);
            rewind_pulse_out_n <= ~(rew_cnt_q != CNT_ZERO);
            offline_req_n <= ~(off_cmd && sel_onl);
        end
    end

    // status to the controller
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            online_status_n <= 1'b1;
            rewinding_status_n <= 1'b1;
            write_protected_status_n <= 1'b1;
            load_point_status_n <= 1'b1;
            ready_status_n <= 1'b1;
            end_of_tape_status_n <= 1'b1;
            tape_running_status_n <= 1'b1;
        end
        else
        begin
            online_status_n <= ~sel_onl;
            rewinding_status_n <= ~((rew_q && sel_onl) || panel);
            write_protected_status_n <= ~(sel_onl && in_q[IN_WP]);
            load_point_status_n <= ~(sel_onl && lp && !rewinding);
            ready_status_n <= ~(sel_onl && !busy && !rewinding);
            end_of_tape_status_n <= ~(sel_onl && eot_q);
            tape_running_status_n <= ~(sel_onl && moving);
        end
    end

    // register port: one wait cycle, then a one-cycle acknowledge
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_q <= BUS_IDLE;
            waitrequest <= 1'b1;
            readdata <= READ_ZERO;
        end
        else
        begin
            case (bus_q)
                BUS_IDLE:
                begin
                    if (read || write)
                    begin
                        bus_q <= BUS_ACK;
                        waitrequest <= 1'b0;
                        if (!read)
                            readdata <= READ_ZERO;
                        else if (address == CTRL_ADDR)
                            readdata <= ctrl_q;
                        else if (address == STATUS_ADDR)
                            readdata <= {25'h0000000, sel_onl, eot_q,
                                rew_q, ovw_mode_q, write_q,
                                interlock_q, dir_q};
                        else
                            readdata <= READ_ZERO;
                    end
                end
                default:
                begin
                    bus_q <= BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_q <= CTRL_RESET;
        else if (write && !waitrequest && address == CTRL_ADDR
            && byteenable[0])
            ctrl_q <= {24'h000000, writedata[7:0]};
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    interlock_run_a: assert property (interlock_q |=> run_normal_n)
        else $error("run normal active while interlock set");
    interlock_clr_a: assert property (!moving |=> !interlock_q)
        else $error("interlock not clear while tape stopped");
    dir_set_a: assert property (sync_forward_cmd && !src |=> dir_q)
        else $error("forward command did not set direction");
    fwd_out_a: assert property (dir_q && sel_onl && !busy
        |=> !dir_forward_n)
        else $error("forward output missing");
    rev_lp_a: assert property (lp |=> dir_reverse_n)
        else $error("reverse output at load point");
    write_cap_a: assert property (sample_end
        |=> write_q == $past(set_write_status))
        else $error("write flop did not capture write status");
    sample_len_a: assert property (motion_start
        |=> (sample_cnt_q != CNT_ZERO) [*8])
        else $error("write sample pulse too short");
    ovw_clr_a: assert property (war && !(motion_start && overwrite_cmd)
        |=> !ovw_mode_q)
        else $error("overwrite mode survived reset pulse");
    rew_set_a: assert property (rewind_cmd && sel_onl && !lp && !broken
        |=> rew_q)
        else $error("rewind flop not set");
    rew_pulse_a: assert property ($rose(rew_q)
        |=> ##1 !rewind_pulse_out_n)
        else $error("rewind pulse not issued");
    eot_broken_a: assert property (broken |=> !eot_q)
        else $error("end latch not cleared by broken tape");
    ready_out_a: assert property (sel_onl && !busy && !rewinding
        |=> !ready_status_n)
        else $error("ready status missing");
    panel_rew_a: assert property (panel |=> !rewinding_status_n)
        else $error("panel rewind status blocked");
    bus_ack_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    dir_change_c: cover property (moving && dir_chg ##1 interlock_q);
    overwrite_c: cover property (ovw_mode_q && ovw_cap_q && !write_select_n);
    rewind_c: cover property ($rose(rew_q) ##[1:20] !rewinding_status_n);
    eot_rev_c: cover property (eot_q ##1 !eot_q && !broken);
endmodule

// [tb/tape_ctrl_model.sv]
// Purpose: tape controller side model driving the command pins
// Assumes: bench gives active-high requests, changed just after an edge
// Notes: pins are registered, so a request reaches them one clock later
`timescale 1ns/1ps
module tape_ctrl_model
(
    input wire logic clk_sys,
    input wire logic [1:0] motion,
    input wire logic wr,
    input wire logic overwrite_cmd,
    input wire logic rew,
    input wire logic sel,
    input wire logic off,
    output logic sync_forward_cmd_n,
    output logic sync_reverse_cmd_n,
    output logic set_write_status_n,
    output logic overwrite_cmd_n,
    output logic rewind_cmd_n,
    output logic unit_select_n,
    output logic go_offline_cmd_n
);
    // pins are unknown until the first edge, which falls inside reset
    // write status moves with motion so it stands through the sample
    always @(posedge clk_sys)
    begin
        sync_forward_cmd_n <= !(motion == 2'h1);
        sync_reverse_cmd_n <= !(motion == 2'h2);
        set_write_status_n <= !wr;
        overwrite_cmd_n <= !overwrite_cmd;
        rewind_cmd_n <= !rew;
        unit_select_n <= !sel;
        go_offline_cmd_n <= !off;
    end
endmodule

// [tb/tape_transport_interface_control_tb_top.sv]
// Purpose: self-checking bench for the tape interface control
// Assumes: 200 MHz clock, short sample and pulse counts
// Notes: pin effects are checked six clocks after a change
`timescale 1ns/1ps
module tape_transport_interface_control_tb_top;
    import tape_if_pkg::*;
    localparam int WS = 9;
    localparam int RP = 4;
    logic clk_sys, reset_n, read, write;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, cnt;
    logic waitrequest, wp;
    logic [1:0] motion;
    logic wr, overwrite_cmd, rew, sel, off;
    logic sync_forward_cmd_n, sync_reverse_cmd_n, overwrite_cmd_n;
    logic rewind_cmd_n, unit_select_n, set_write_status_n, go_offline_cmd_n;
    logic tape_moving_n, at_load_point_n, tape_end_marker_n, busy_in_n;
    logic broken_tape_n, write_amp_reset_n, panel_rewind_n, unit_online_n;
    logic write_protect_n, run_normal_n, dir_forward_n, dir_reverse_n;
    logic write_select_n, erase_head_disable_n, rewind_pulse_out_n;
    logic offline_req_n, online_status_n, rewinding_status_n;
    logic write_protected_status_n, load_point_status_n, ready_status_n;
    logic end_of_tape_status_n, tape_running_status_n;
    logic [13:0] outs;
    logic [36:0] q[$];
    logic [36:0] ent;
    event probe;
    int mismatches = 0;
    int checks = 0;
    int seed = 32'h6213;
    assign outs = {tape_running_status_n, end_of_tape_status_n,
        ready_status_n, load_point_status_n, write_protected_status_n,
        rewinding_status_n, online_status_n, offline_req_n,
        rewind_pulse_out_n, erase_head_disable_n, write_select_n,
        dir_reverse_n, dir_forward_n, run_normal_n};
    tape_ctrl_model tape_ctrl_model_inst (.clk_sys, .motion, .wr, .overwrite_cmd,
        .rew, .sel, .off, .sync_forward_cmd_n, .sync_reverse_cmd_n,
        .set_write_status_n, .overwrite_cmd_n, .rewind_cmd_n,
        .unit_select_n, .go_offline_cmd_n);
    tape_if_ctrl #(.WRITE_SAMPLE(16'h0009), .REWIND_PULSE(16'h0004))
        tape_if_ctrl_inst (.clk_sys, .reset_n, .sync_forward_cmd_n,
        .sync_reverse_cmd_n, .overwrite_cmd_n, .rewind_cmd_n, .unit_select_n,
        .set_write_status_n, .go_offline_cmd_n, .tape_moving_n,
        .at_load_point_n, .tape_end_marker_n, .busy_in_n, .broken_tape_n,
        .write_amp_reset_n, .panel_rewind_n, .unit_online_n, .write_protect_n,
        .address, .read, .write, .byteenable, .writedata, .readdata,
        .waitrequest, .run_normal_n, .dir_forward_n, .dir_reverse_n,
        .write_select_n, .erase_head_disable_n, .rewind_pulse_out_n,
        .offline_req_n, .online_status_n, .rewinding_status_n,
        .write_protected_status_n, .load_point_status_n, .ready_status_n,
        .end_of_tape_status_n, .tape_running_status_n);
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end
    task automatic complete_run();
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // the watcher: bus reads and pin probes both take the oldest note
    always @(posedge clk_sys)
    begin
        if (read && waitrequest === 1'b0)
        begin
            ent = q.size() > 0 ? q.pop_front() : '1;
            check(readdata, ent[31:0]);
        end
    end
    always @(probe)
    begin
        ent = q.size() > 0 ? q.pop_front() : '1;
        check(ent[36:32] == 5'h15 ? cnt : {31'h0, outs[ent[36:32]]},
            ent[31:0]);
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic pin(input int i, input logic e);
        q.push_back({5'(i), 31'h0, e});
        -> probe;
        @(posedge clk_sys);
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        @(posedge clk_sys);
        while (waitrequest !== 1'b0 && n < 50)
        begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 50)
        begin
            mismatches++;
            complete_run();
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        q.push_back({5'h14, e});
        bus(1'b0, a, 32'h0000_0000);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        complete_run();
    end
    initial
    begin
        reset_n = 1'b0;
        {read, write, address, byteenable, writedata} = {10'h00F, 32'h0};
        {motion, wr, overwrite_cmd, rew, sel, off} = 7'h00;
        {tape_moving_n, at_load_point_n, tape_end_marker_n} = 3'h7;
        {busy_in_n, broken_tape_n, write_amp_reset_n} = 3'h7;
        {panel_rewind_n, unit_online_n, write_protect_n} = 3'h7;
        tick(5);
        reset_n <= 1'b1;
        tick(2);
        rd(4'h8, READ_ZERO);
        rd(CTRL_ADDR, CTRL_RESET);
        sel <= 1'b1;
        unit_online_n <= 1'b0;
        bus(1'b1, CTRL_ADDR, 32'h0000_0001);
        rd(CTRL_ADDR, 32'h0000_0001);
        pin(7, 1'b1);
        bus(1'b1, CTRL_ADDR, 32'h0000_0000);
        tick(6);
        pin(7, 1'b0);
        pin(11, 1'b0);
        pin(0, 1'b1);
        repeat (4)
        begin
            wp = 1'($random(seed));
            write_protect_n <= !wp;
            tick(6);
            pin(9, !wp);
        end
        off <= 1'b1;
        tick(6);
        pin(6, 1'b0);
        off <= 1'b0;
        // forward write: select latches at the end of the sample window and outlives motion
        motion <= 2'h1;
        wr <= 1'b1;
        tick(6);
        pin(0, 1'b0);
        pin(1, 1'b0);
        pin(2, 1'b1);
        tick(WS + 6);
        pin(3, 1'b0);
        rd(STATUS_ADDR, 32'h0000_0045);
        motion <= 2'h0;
        wr <= 1'b0;
        tick(6);
        pin(3, 1'b0);
        motion <= 2'h1;
        tape_end_marker_n <= 1'b0;
        tick(6);
        pin(12, 1'b0);
        motion <= 2'h2;
        tick(6);
        pin(12, 1'b0);
        tape_end_marker_n <= 1'b1;
        tick(6);
        pin(12, 1'b1);
        at_load_point_n <= 1'b0;
        tick(6);
        pin(2, 1'b1);
        pin(0, 1'b1);
        at_load_point_n <= 1'b1;
        tick(6);
        pin(2, 1'b0);
        pin(1, 1'b1);
        // direction change while moving must stop run until tape halts
        tape_moving_n <= 1'b0;
        motion <= 2'h1;
        // the interlock sets one clock after the direction flop moves
        tick(8);
        pin(0, 1'b1);
        pin(1, 1'b0);
        pin(13, 1'b0);
        tape_moving_n <= 1'b1;
        tick(6);
        pin(0, 1'b0);
        motion <= 2'h0;
        tick(6);
        {overwrite_cmd, wr, motion} <= 4'hD;
        tick(WS + 8);
        pin(4, 1'b0);
        pin(3, 1'b0);
        {overwrite_cmd, motion} <= 3'h0;
        tick(6);
        pin(3, 1'b1);
        write_amp_reset_n <= 1'b0;
        tick(3);
        write_amp_reset_n <= 1'b1;
        wr <= 1'b0;
        tick(6);
        pin(4, 1'b1);
        rew <= 1'b1;
        cnt = 32'h0000_0000;
        repeat (40)
        begin
            @(posedge clk_sys);
            cnt = cnt + {31'h0, rewind_pulse_out_n === 1'b0};
        end
        q.push_back({5'h15, 32'(RP)});
        -> probe;
        tick(1);
        pin(8, 1'b0);
        rew <= 1'b0;
        at_load_point_n <= 1'b0;
        tick(6);
        pin(8, 1'b1);
        pin(10, 1'b0);
        rew <= 1'b1;
        tick(6);
        pin(8, 1'b1);
        {rew, at_load_point_n, motion, tape_end_marker_n} <= 5'h1A;
        tick(6);
        rew <= 1'b0;
        pin(8, 1'b0);
        broken_tape_n <= 1'b0;
        tick(6);
        pin(8, 1'b1);
        pin(12, 1'b1);
        {broken_tape_n, tape_end_marker_n, motion} <= 4'hC;
        busy_in_n <= 1'b0;
        tick(6);
        pin(11, 1'b1);
        pin(1, 1'b1);
        {busy_in_n, at_load_point_n, panel_rewind_n} <= 3'h4;
        tick(6);
        pin(10, 1'b1);
        sel <= 1'b0;
        tick(6);
        pin(8, 1'b0);
        pin(7, 1'b1);
        tick(2);
        complete_run();
    end
endmodule
